/* rom_core.v */
// Summary of operation
// - High side turns on only after a complete dead interval following low-side off.
// - On-time counter counts up in 10 ns steps until comparator trips.
// - Comparator trip turns high side off and inserts dead interval before low side.
// - Low side counts stored on-time down to zero, matching high-side on-time.
// - Down count at zero turns low side off and starts a new dead interval.
// - Comparator output ignored during blanking interval after high-side turn-on.
// - Comparator stuck active across cycles: replay last valid on-time until recovery.
// - During startup the soft-start output replaces the scaled feedback set point.
// - Feedforward current source enabled only while bulk voltage good is high.
// - Front-stage enable output pulled low before controller startup.
// - Front-stage enable output pulled low in protection with self-supply mode.
// - Active state releases pull-down and closes the current-limited bypass switch.
// - Bulk voltage good high only when above brown-out threshold and run allowed.
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "rom_consts.vh"

module rom_core #(
  parameter CNT_W = 16
) (
  input  wire              pclk,
  input  wire              presetn,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [11:0]       paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  input  wire              ontime_cmp,
  input  wire              bulk_above_bo,
  output reg               high_side_on,
  output reg               low_side_on,
  output reg               softstart_select,
  output reg               feedforward_current_en,
  output reg               bulk_voltage_good,
  output reg               enable_output_pulldown,
  output reg               enable_output_bypass
);

  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_DEAD = 4'b0010;
  localparam [3:0] ST_HIGH = 4'b0100;
  localparam [3:0] ST_LOW  = 4'b1000;

  localparam [CNT_W-1:0] CNT_MAX  = {CNT_W{1'b1}};
  localparam [31:0]      STEP_32  = `ROM_STEPS_PER_CYC;
  localparam [CNT_W-1:0] STEP     = STEP_32[CNT_W-1:0];

  localparam [31:0]      DEAD_32  = `ROM_DEAD_CYC;
  localparam [31:0]      BLK_32   = `ROM_BLANK_CYC;

  // Loaded one short: the timer also spends a cycle at zero
  localparam [7:0]       DEAD_CYC = DEAD_32[7:0] - 8'h01;
  localparam [7:0]       BLK_CYC  = BLK_32[7:0];

  reg  [3:0]       state;
  reg  [3:0]       next_state;
  reg  [CNT_W-1:0] ontime;
  reg  [CNT_W-1:0] next_ontime;
  reg  [CNT_W-1:0] last_valid;
  reg  [CNT_W-1:0] next_last_valid;
  reg  [7:0]       timer;
  reg  [7:0]       next_timer;
  reg              replay;
  reg              next_replay;
  reg              trip_seen;
  reg              next_trip_seen;
  reg  [3:0]       ctrl;
  wire             run;
  wire             protect_ss;
  wire             active;
  wire             cmp_valid;
  wire             wr_en;
  wire             rd_en;

  wire             addr_ctrl;
  wire             addr_status;
  wire             addr_ontime;
  wire             addr_hit;

  wire [31:0]      status_word;
  wire [31:0]      ctrl_word;
  wire [31:0]      ontime_word;

  reg  [31:0]      next_prdata;
  reg              next_pslverr;
  reg              next_pready;
  reg  [3:0]       next_ctrl;

  reg              next_high_side_on;
  reg              next_low_side_on;
  reg              next_bulk_good;
  reg              next_pulldown;
  reg              next_bypass;

  assign run        = ctrl[`ROM_CTRL_RUN];
  assign protect_ss = ctrl[`ROM_CTRL_PROTECT] & ctrl[`ROM_CTRL_SELFSUP];
  assign active     = run & bulk_voltage_good & ~protect_ss;
  // Comparator ignored while blanking runs
  assign cmp_valid  = ontime_cmp & (timer == 8'h00);
  assign wr_en      = psel & penable & pwrite & ~pready;
  assign rd_en      = psel & penable & ~pwrite & ~pready;

  // Status word, one field per bit, upper bits read as zero
  assign status_word[`ROM_ST_HIGH]   = high_side_on;
  assign status_word[`ROM_ST_LOW]    = low_side_on;
  assign status_word[`ROM_ST_DEAD]   = state[1];
  assign status_word[`ROM_ST_REPLAY] = replay;
  assign status_word[`ROM_ST_BULK]   = bulk_voltage_good;
  assign status_word[`ROM_ST_ENOUT]  = enable_output_bypass;
  assign status_word[`ROM_ST_FF]     = feedforward_current_en;
  assign status_word[31:7]           = 25'h0000000;

  assign ctrl_word   = {28'h0000000, ctrl};
  assign ontime_word = {{(32-CNT_W){1'b0}}, last_valid};

  // Register decode
  assign addr_ctrl   = (paddr == `ROM_REG_CTRL);
  assign addr_status = (paddr == `ROM_REG_STATUS);
  assign addr_ontime = (paddr == `ROM_REG_ONTIME);
  assign addr_hit    = addr_ctrl | addr_status | addr_ontime;

  // Switching sequence
  always @* begin
    next_state      = state;
    next_ontime     = ontime;
    next_last_valid = last_valid;
    next_timer      = (timer != 8'h00) ? timer - 8'h01 : 8'h00;
    next_replay     = replay;
    next_trip_seen  = trip_seen;
    case (state)
      ST_IDLE: begin
        next_ontime = {CNT_W{1'b0}};
        if (active) begin
          next_state = ST_DEAD;
          next_timer = DEAD_CYC;
        end
      end
      ST_DEAD: begin
        if (!active) begin
          next_state = ST_IDLE;
        end else if (timer == 8'h00) begin
          if (trip_seen) begin
            next_state = ST_LOW;
          end else begin
            // High side only once the dead interval is over
            next_state     = ST_HIGH;
            next_timer     = BLK_CYC;
            next_ontime    = {CNT_W{1'b0}};
            // Comparator already active at turn-on means a stuck cycle
            next_replay    = ontime_cmp & (last_valid != {CNT_W{1'b0}});
          end
        end
      end
      ST_HIGH: begin
        if (!active) begin
          next_state = ST_IDLE;
        end else if (replay) begin
          if (ontime >= last_valid) begin
            next_state     = ST_DEAD;
            next_timer     = DEAD_CYC;
            next_trip_seen = 1'b1;
          end else if (CNT_MAX - ontime < STEP) begin
            next_ontime = CNT_MAX;
          end else begin
            next_ontime = ontime + STEP;
          end
        end else if (cmp_valid) begin
          next_state      = ST_DEAD;
          next_timer      = DEAD_CYC;
          next_trip_seen  = 1'b1;
          next_last_valid = ontime;
        end else if (CNT_MAX - ontime < STEP) begin
          next_ontime = CNT_MAX;
        end else begin
          next_ontime = ontime + STEP;
        end
      end
      ST_LOW: begin
        next_trip_seen = 1'b0;
        if (!active) begin
          next_state = ST_IDLE;
        end else if (ontime < STEP) begin
          next_ontime = {CNT_W{1'b0}};
          next_state  = ST_DEAD;
          next_timer  = DEAD_CYC;
        end else begin
          next_ontime = ontime - STEP;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (next_state == ST_IDLE) begin
      next_trip_seen = 1'b0;
      next_replay    = 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= ST_IDLE;
      ontime     <= {CNT_W{1'b0}};
      last_valid <= {CNT_W{1'b0}};
      timer      <= 8'h00;
      replay     <= 1'b0;
      trip_seen  <= 1'b0;
    end else begin
      state      <= next_state;
      ontime     <= next_ontime;
      last_valid <= next_last_valid;
      timer      <= next_timer;
      replay     <= next_replay;
      trip_seen  <= next_trip_seen;
    end
  end

  // Next values of the pin drives
  always @* begin
    next_high_side_on = (next_state == ST_HIGH);
    next_low_side_on  = (next_state == ST_LOW);
    next_bulk_good    = bulk_above_bo & run;

    if (!active) begin
      // Pulled low before startup and in protection with self-supply
      next_pulldown = 1'b1;
      next_bypass   = 1'b0;
    end else begin
      next_pulldown = 1'b0;
      next_bypass   = 1'b1;
    end
  end

  // Switch drives and front-stage control
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_side_on           <= 1'b0;
      low_side_on            <= 1'b0;
      softstart_select       <= 1'b0;
      feedforward_current_en <= 1'b0;
      bulk_voltage_good      <= 1'b0;
      enable_output_pulldown <= 1'b1;
      enable_output_bypass   <= 1'b0;
    end else begin
      high_side_on           <= next_high_side_on;
      low_side_on            <= next_low_side_on;
      softstart_select       <= ctrl[`ROM_CTRL_SOFTSTART];

      bulk_voltage_good      <= next_bulk_good;
      // Same gate as the bulk-good flag so both move together
      feedforward_current_en <= next_bulk_good;

      enable_output_pulldown <= next_pulldown;
      enable_output_bypass   <= next_bypass;
    end
  end

  // APB slave, one wait state: taken in the first access cycle
  always @* begin
    next_pready  = psel & penable & ~pready;
    next_pslverr = 1'b0;
    next_prdata  = 32'h00000000;
    next_ctrl    = ctrl;

    if (wr_en) begin
      if (addr_ctrl) begin
        next_ctrl[`ROM_CTRL_RUN]       = pwdata[`ROM_CTRL_RUN];
        next_ctrl[`ROM_CTRL_SOFTSTART] = pwdata[`ROM_CTRL_SOFTSTART];
        next_ctrl[`ROM_CTRL_PROTECT]   = pwdata[`ROM_CTRL_PROTECT];
        next_ctrl[`ROM_CTRL_SELFSUP]   = pwdata[`ROM_CTRL_SELFSUP];
      end
      // Writes to read-only words are ignored without error
      next_pslverr = ~addr_hit;
    end

    if (rd_en) begin
      case (paddr)
        `ROM_REG_CTRL: begin
          next_prdata = ctrl_word;
        end

        `ROM_REG_STATUS: begin
          next_prdata = status_word;
        end

        `ROM_REG_ONTIME: begin
          next_prdata = ontime_word;
        end

        default: begin
          next_pslverr = 1'b1;
        end
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl    <= `ROM_CTRL_RESET;
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      ctrl    <= next_ctrl;
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

endmodule

`default_nettype wire

/* rom_consts.vh */
`ifndef ROM_CONSTS_VH
`define ROM_CONSTS_VH

// Clock period and on-time step, in ns
`define ROM_CLK_NS          100
`define ROM_STEP_NS         10
// Dead interval and blanking interval, in ns
`define ROM_DEAD_NS         500
`define ROM_BLANK_NS        300
`define ROM_DEAD_CYC        ((`ROM_DEAD_NS + `ROM_CLK_NS - 1) / `ROM_CLK_NS)
`define ROM_BLANK_CYC       ((`ROM_BLANK_NS + `ROM_CLK_NS - 1) / `ROM_CLK_NS)
// On-time counter steps per clock cycle
`define ROM_STEPS_PER_CYC   (`ROM_CLK_NS / `ROM_STEP_NS)

// APB register byte offsets
`define ROM_REG_CTRL        12'h000
`define ROM_REG_STATUS      12'h004
`define ROM_REG_ONTIME      12'h008

// Control register fields
`define ROM_CTRL_RUN        0
`define ROM_CTRL_SOFTSTART  1
`define ROM_CTRL_PROTECT    2
`define ROM_CTRL_SELFSUP    3
`define ROM_CTRL_RESET      4'h0

// Status register fields
`define ROM_ST_HIGH         0
`define ROM_ST_LOW          1
`define ROM_ST_DEAD         2
`define ROM_ST_REPLAY       3
`define ROM_ST_BULK         4
`define ROM_ST_ENOUT        5
`define ROM_ST_FF           6

`endif

/* rom_core_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module rom_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic high_side_on,
  input wire logic low_side_on,
  input wire logic bulk_above_bo,
  input wire logic bulk_voltage_good,
  input wire logic feedforward_current_en,
  input wire logic enable_output_pulldown,
  input wire logic enable_output_bypass
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence dead5;
    (!high_side_on && !low_side_on) [*5];
  endsequence
  sequence blank3;
    high_side_on [*3];
  endsequence
  chk_dead_high: assert property ($fell(low_side_on) |-> dead5)
    else $error("short dead interval after low side");
  chk_dead_low: assert property ($fell(high_side_on) |-> dead5)
    else $error("short dead interval after high side");
  chk_no_overlap: assert property (!(high_side_on && low_side_on))
    else $error("both switches on");
  chk_blank_hold: assert property ($rose(high_side_on) |-> blank3)
    else $error("high side ended inside blanking");
  chk_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  chk_ff_gate: assert property (feedforward_current_en == bulk_voltage_good)
    else $error("feedforward not gated");
  chk_bulk_gate: assert property (bulk_voltage_good |-> $past(bulk_above_bo))
    else $error("bulk good without bulk");
  chk_en_onehot: assert property (enable_output_pulldown ^ enable_output_bypass)
    else $error("enable output not one-hot");
  chk_run_bypass: assert property (high_side_on || low_side_on |-> enable_output_bypass)
    else $error("switching without bypass");
endmodule
`default_nettype wire

/* rom_stage.sv */
`timescale 1ns/1ps
`default_nettype none
module rom_stage (
  input  wire logic       pclk,
  input  wire logic       high_side_on,
  input  wire logic [7:0] trip_len,
  input  wire logic       stuck,
  output logic            ontime_cmp
);
  int n = 0;
  // Current ramps while high side conducts; stuck models unbalanced tank
  always @(posedge pclk) begin
    n <= high_side_on ? n + 1 : 0;
    ontime_cmp <= stuck || (high_side_on && n + 1 >= trip_len);
  end
endmodule
`default_nettype wire

/* resonant_ontime_modulator_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rom_consts.vh"
module resonant_ontime_modulator_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic [7:0] trip_len = 8'h06;
  logic pready, pslverr, er, ontime_cmp, bulk_above_bo = 0, stuck = 0;
  logic high_side_on, low_side_on, softstart_select, feedforward_current_en;
  logic bulk_voltage_good, enable_output_pulldown, enable_output_bypass;
  int n_mismatch = 0, comparisons = 0, h, l, h1, v1, t;
  always #50 pclk = ~pclk;
  rom_core rom_core_inst (.*);
  rom_stage rom_stage_inst (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1;
    t = 0;
    do begin @(posedge pclk); t++; end while (pready !== 1'b1 && t < 20);
    if (t == 20) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, 32'h0, 32'h1);
      wrap_up;
    end
    rd = prdata; er = pslverr;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  task automatic meas(output int hi, output int lo);
    t = 0; hi = 0; lo = 0;
    while (high_side_on !== 1'b1 && t < 500) begin @(posedge pclk); t++; end
    while (high_side_on === 1'b1) begin @(posedge pclk); hi++; end
    while (low_side_on !== 1'b1 && t < 500) begin @(posedge pclk); t++; end
    while (low_side_on === 1'b1) begin @(posedge pclk); lo++; end
  endtask
  // High-side length: trip one cycle after the comparator, never inside blanking
  function automatic int exp_hi(input int trip);
    exp_hi = (trip + 1 > `ROM_BLANK_CYC + 1) ? trip + 1 : `ROM_BLANK_CYC + 1;
  endfunction
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #1_000_000;
    n_mismatch++;
    wrap_up;
  end
  initial begin
    t = $urandom(44400);
    repeat (20) @(posedge pclk);
    chk(enable_output_pulldown, 1);
    chk(high_side_on | low_side_on, 0);
    presetn <= 1; bulk_above_bo <= 1;
    @(posedge pclk);
    apb(1, 12'h000, 32'h00000001);
    repeat (2) @(posedge pclk);
    chk({enable_output_bypass, enable_output_pulldown}, 2);
    chk({feedforward_current_en, bulk_voltage_good}, 3);
    $display("test startup done");
    for (int i = 0; i < 5; i++) begin
      trip_len <= (i == 0) ? 8'h04 : 8'($urandom_range(5, 30));
      meas(h, l); meas(h, l);
      chk(l, h);
      chk(h, exp_hi(trip_len));
      apb(0, 12'h008, 0);
      if (i == 0) begin h1 = h; v1 = rd; end
      else chk(rd, v1 + 10 * (h - h1));
    end
    $display("test ontime done");
    h1 = h;
    while (low_side_on !== 1'b1) @(posedge pclk);
    stuck <= 1;
    meas(h, l); meas(h, l);
    chk(h, h1);
    chk(l, h);
    stuck <= 0; trip_len <= 8'h01;
    meas(h, l); meas(h, l);
    chk(l, h);
    chk(h, `ROM_BLANK_CYC + 1);
    $display("test replay blank done");
    apb(0, 12'h008, 0); v1 = rd;
    apb(1, 12'h008, 32'h0000FFFF);
    apb(0, 12'h008, 0);
    chk(rd, v1);
    apb(0, 12'h0FC, 0);
    chk(er, 1);
    apb(1, 12'h000, 32'h00000003);
    chk(softstart_select, 1);
    bulk_above_bo <= 0;
    repeat (3) @(posedge pclk);
    chk({feedforward_current_en, bulk_voltage_good, enable_output_bypass}, 0);
    bulk_above_bo <= 1;
    apb(1, 12'h000, 32'h0000000D);
    repeat (2) @(posedge pclk);
    chk({enable_output_pulldown, high_side_on, low_side_on}, 4);
    apb(1, 12'h000, 32'h00000005);
    repeat (2) @(posedge pclk);
    chk(enable_output_bypass, 1);
    $display("test modes done");
    wrap_up;
  end
endmodule
bind rom_core rom_chk rom_chk_inst (.*);
`default_nettype wire
